//--- dcr_regs.v
/*
 Timing and configuration register file of a dynamic memory controller,
 reached over APB, with a chip-select address probe and per-master QoS table.
 Assumes an APB master on i_clk, and the command engine reporting its
 state on i_ctrl_state and sampling the configuration outputs.
*/
// The APB slave port was decided locally.
// What this block does
// - Timing, setup, QoS and chip registers accessible only in config or low-power
// - Write-recovery field, 3 bits, resets to three
// - Write-to-read delay, 3 bits, resets to two
// - Power-down exit wait, 8 bits, resets one
// - Self-refresh exit wait, 8 bits, resets ten
// - Self-refresh entry time, 8 bits, resets twenty
// - Pad read latency, 2 bits, resets zero
// - Memory type field selects SDR/DDR/eDRAM/LPDDR
// - Width field selects 16/32/64, 11 reserved
// - Clock-enable output follows its init bit in config state
// - Data mask outputs follow their init bit in config state, low otherwise
// - Refresh prescaler 9 bits, outstanding limit 3
// - Masters identified by ID in 0x20 steps
// - Per-master QoS enable, max and min fields
// - Chip bit selects row-bank or bank-row decode
// - Match value compared with address bits 31:24
// - Mask bit one includes that address bit
`timescale 1ns/1ps
`include "dcr_defs.vh"

module dcr_regs
(
   // Clock and reset
   input wire i_clk,
   input wire i_arst_n,
   // APB slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // Controller state from the command engine
   input wire [1:0] i_ctrl_state,
   // Timing values to the command engine
   output reg [2:0] o_wr_recovery,
   output reg [2:0] o_wr_to_rd,
   output reg [7:0] o_pd_exit,
   output reg [7:0] o_sr_exit,
   output reg [7:0] o_sr_entry,
   // Memory setup to the command engine
   output reg [1:0] o_read_delay,
   output reg o_is_ddr,
   output reg o_is_lpddr,
   output reg [1:0] o_bytes_log2,
   output reg o_width_bad,
   output reg o_sync,
   output reg o_bus_clock_faster_flag,
   output reg [8:0] o_prescale,
   output reg [2:0] o_max_outs_refs,
   output reg o_bank_row_col,
   // Memory pins after reset
   output reg o_mem_cke,
   output reg o_mem_dqm,
   // QoS lookup by AXI ID
   input wire [7:0] i_axi_id,
   output reg o_qos_enable,
   output reg [7:0] o_qos_max,
   output reg o_qos_min,
   // Chip select by AXI address
   input wire [7:0] i_axi_addr_hi,
   output reg o_chip_hit
);

   reg [2:0] wr_recovery;
   reg [2:0] wr_to_rd;
   reg [7:0] pd_exit;
   reg [7:0] sr_exit;
   reg [7:0] sr_entry;
   reg [10:0] mem_setup2;
   reg [11:0] refresh;
   reg [9:0] qos [0:`DCR_NUM_MASTERS-1];
   reg [16:0] chip_sel;
   reg [7:0] cs_probe;
   reg [31:0] next_prdata;
   reg next_pslverr;
   wire cfg_open;
   wire setup;
   wire wr_ok;
   wire [2:0] qos_idx;
   wire qos_hit;
   wire [2:0] id_idx;
   genvar gi;

   // Chip-select comparison over masked upper address bits
   function cs_match;
      input [7:0] addr_hi;
      input [16:0] cfg;
      begin
         cs_match = ((addr_hi ^ cfg[`DCR_CS_MATCH_HI:`DCR_CS_MATCH_LO])
                     & cfg[`DCR_CS_MASK_HI:`DCR_CS_MASK_LO]) == 8'h00;
      end
   endfunction

   // Access window open in config or low-power state
   assign cfg_open = (i_ctrl_state == `DCR_ST_CONFIG) || (i_ctrl_state == `DCR_ST_LOWPWR);
   assign setup = i_psel && !i_penable;
   assign wr_ok = i_psel && i_penable && o_pready && i_pwrite && cfg_open && !o_pslverr;
   assign qos_hit = (i_paddr >= `DCR_OFS_QOS_BASE) && (i_paddr <= `DCR_OFS_QOS_LAST)
                    && (i_paddr[1:0] == 2'h0);
   assign qos_idx = i_paddr[4:2];
   // ID to table slot, one slot per 0x20 step
   assign id_idx = i_axi_id[7:5];

   // Read data and error decode in the setup cycle
   always @*
   begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (i_paddr == `DCR_OFS_STATE)
      begin
         next_prdata = {30'h0000_0000, i_ctrl_state};
      end
      else if (i_paddr == `DCR_OFS_CS_PROBE)
      begin
         next_prdata = {24'h00_0000, cs_probe};
      end
      else if (i_paddr == `DCR_OFS_CS_RESULT)
      begin
         next_prdata = {31'h0000_0000, cs_match(cs_probe, chip_sel)};
      end
      else if (!cfg_open)
      begin
         next_pslverr = 1'b0;
         next_prdata = 32'h0000_0000;
         if (!(i_paddr == `DCR_OFS_WR_RECOVERY || i_paddr == `DCR_OFS_WR_TO_RD
             || i_paddr == `DCR_OFS_PD_EXIT || i_paddr == `DCR_OFS_SR_EXIT
             || i_paddr == `DCR_OFS_SR_ENTRY || i_paddr == `DCR_OFS_MEM_SETUP2
             || i_paddr == `DCR_OFS_REFRESH || i_paddr == `DCR_OFS_CHIP_SEL || qos_hit))
         begin
            next_pslverr = 1'b1;
         end
      end
      else if (i_paddr == `DCR_OFS_WR_RECOVERY)
      begin
         next_prdata = {29'h0000_0000, wr_recovery};
      end
      else if (i_paddr == `DCR_OFS_WR_TO_RD)
      begin
         next_prdata = {29'h0000_0000, wr_to_rd};
      end
      else if (i_paddr == `DCR_OFS_PD_EXIT)
      begin
         next_prdata = {24'h00_0000, pd_exit};
      end
      else if (i_paddr == `DCR_OFS_SR_EXIT)
      begin
         next_prdata = {24'h00_0000, sr_exit};
      end
      else if (i_paddr == `DCR_OFS_SR_ENTRY)
      begin
         next_prdata = {24'h00_0000, sr_entry};
      end
      else if (i_paddr == `DCR_OFS_MEM_SETUP2)
      begin
         next_prdata = {21'h00_0000, mem_setup2};
      end
      else if (i_paddr == `DCR_OFS_REFRESH)
      begin
         next_prdata = {20'h0_0000, refresh};
      end
      else if (qos_hit)
      begin
         // Upper half of the window holds no slots and reads zero
         if (!i_paddr[5])
         begin
            next_prdata = {22'h00_0000, qos[qos_idx]};
         end
      end
      else if (i_paddr == `DCR_OFS_CHIP_SEL)
      begin
         next_prdata = {15'h0000, chip_sel};
      end
      else
      begin
         next_pslverr = 1'b1;
      end
   end

   // APB answer: no wait state, ready in the first access cycle
   always @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= setup;
         if (setup)
         begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : next_prdata;
            o_pslverr <= next_pslverr;
         end
         else if (o_pready)
         begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
         end
      end
   end

   // Timing, setup and chip registers
   always @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         wr_recovery <= `DCR_RST_WR_RECOVERY;
         wr_to_rd <= `DCR_RST_WR_TO_RD;
         pd_exit <= `DCR_RST_PD_EXIT;
         sr_exit <= `DCR_RST_SR_EXIT;
         sr_entry <= `DCR_RST_SR_ENTRY;
         mem_setup2 <= `DCR_RST_MEM_SETUP2;
         refresh <= `DCR_RST_REFRESH;
         chip_sel <= `DCR_RST_CHIP_SEL;
         cs_probe <= 8'h00;
      end
      else
      begin
         if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `DCR_OFS_CS_PROBE)
         begin
            cs_probe <= i_pwdata[7:0];
         end
         if (wr_ok)
         begin
            if (i_paddr == `DCR_OFS_WR_RECOVERY)
            begin
               wr_recovery <= i_pwdata[2:0];
            end
            else if (i_paddr == `DCR_OFS_WR_TO_RD)
            begin
               wr_to_rd <= i_pwdata[2:0];
            end
            else if (i_paddr == `DCR_OFS_PD_EXIT)
            begin
               pd_exit <= i_pwdata[7:0];
            end
            else if (i_paddr == `DCR_OFS_SR_EXIT)
            begin
               sr_exit <= i_pwdata[7:0];
            end
            else if (i_paddr == `DCR_OFS_SR_ENTRY)
            begin
               sr_entry <= i_pwdata[7:0];
            end
            else if (i_paddr == `DCR_OFS_MEM_SETUP2)
            begin
               mem_setup2 <= i_pwdata[10:0];
            end
            else if (i_paddr == `DCR_OFS_REFRESH)
            begin
               refresh <= i_pwdata[11:0];
            end
            else if (i_paddr == `DCR_OFS_CHIP_SEL)
            begin
               chip_sel <= i_pwdata[16:0];
            end
         end
      end
   end

   // One QoS entry per master slot
   generate
      for (gi = 0; gi < `DCR_NUM_MASTERS; gi = gi + 1)
      begin : g_qos
         always @(posedge i_clk or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               qos[gi] <= `DCR_RST_QOS;
            end
            // Writes to the unused upper words must not alias onto a slot
            else if (wr_ok && qos_hit && !i_paddr[5] && qos_idx == gi)
            begin
               qos[gi] <= i_pwdata[9:0];
            end
         end
      end
   endgenerate

   // Registered configuration outputs to the engine and pins
   always @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_wr_recovery <= `DCR_RST_WR_RECOVERY;
         o_wr_to_rd <= `DCR_RST_WR_TO_RD;
         o_pd_exit <= `DCR_RST_PD_EXIT;
         o_sr_exit <= `DCR_RST_SR_EXIT;
         o_sr_entry <= `DCR_RST_SR_ENTRY;
         o_read_delay <= 2'h0;
         o_is_ddr <= 1'b0;
         o_is_lpddr <= 1'b0;
         o_bytes_log2 <= 2'h1;
         o_width_bad <= 1'b0;
         o_sync <= 1'b0;
         o_bus_clock_faster_flag <= 1'b0;
         o_prescale <= 9'h000;
         o_max_outs_refs <= 3'h0;
         o_bank_row_col <= 1'b0;
         o_mem_cke <= 1'b0;
         o_mem_dqm <= 1'b0;
         o_qos_enable <= 1'b0;
         o_qos_max <= 8'h00;
         o_qos_min <= 1'b0;
         o_chip_hit <= 1'b0;
      end
      else
      begin
         o_wr_recovery <= wr_recovery;
         o_wr_to_rd <= wr_to_rd;
         o_pd_exit <= pd_exit;
         o_sr_exit <= sr_exit;
         o_sr_entry <= sr_entry;
         o_read_delay <= mem_setup2[`DCR_M2_READ_DELAY_HI:`DCR_M2_READ_DELAY_LO];
         // Double-rate modes
         o_is_ddr <= (mem_setup2[`DCR_M2_TYPE_HI:`DCR_M2_TYPE_LO] == `DCR_TYPE_DDR)
                     || (mem_setup2[`DCR_M2_TYPE_HI:`DCR_M2_TYPE_LO] == `DCR_TYPE_LPDDR);
         o_is_lpddr <= mem_setup2[`DCR_M2_TYPE_HI:`DCR_M2_TYPE_LO] == `DCR_TYPE_LPDDR;
         // Width as log2 of bytes; reserved code flagged
         if (mem_setup2[`DCR_M2_WIDTH_HI:`DCR_M2_WIDTH_LO] == `DCR_WIDTH_16)
         begin
            o_bytes_log2 <= 2'h1;
            o_width_bad <= 1'b0;
         end
         else if (mem_setup2[`DCR_M2_WIDTH_HI:`DCR_M2_WIDTH_LO] == `DCR_WIDTH_32)
         begin
            o_bytes_log2 <= 2'h2;
            o_width_bad <= 1'b0;
         end
         else if (mem_setup2[`DCR_M2_WIDTH_HI:`DCR_M2_WIDTH_LO] == `DCR_WIDTH_64)
         begin
            o_bytes_log2 <= 2'h3;
            o_width_bad <= 1'b0;
         end
         else
         begin
            o_bytes_log2 <= 2'h1;
            o_width_bad <= 1'b1;
         end
         o_sync <= mem_setup2[`DCR_M2_SYNC];
         o_bus_clock_faster_flag <= mem_setup2[`DCR_M2_BUS_FASTER];
         o_prescale <= refresh[`DCR_RF_PRESCALE_HI:`DCR_RF_PRESCALE_LO];
         o_max_outs_refs <= refresh[`DCR_RF_MAX_OUTS_HI:`DCR_RF_MAX_OUTS_LO];
         o_bank_row_col <= chip_sel[`DCR_CS_BRC];
         // Pins hold their init levels until the engine leaves config
         if (i_ctrl_state == `DCR_ST_CONFIG)
         begin
            o_mem_cke <= mem_setup2[`DCR_M2_CKE_INIT];
            o_mem_dqm <= mem_setup2[`DCR_M2_DQM_INIT];
         end
         else
         begin
            o_mem_cke <= i_ctrl_state != `DCR_ST_LOWPWR;
            o_mem_dqm <= 1'b0;
         end
         o_qos_enable <= qos[id_idx][`DCR_QOS_EN];
         o_qos_max <= qos[id_idx][`DCR_QOS_MAX_HI:`DCR_QOS_MAX_LO];
         o_qos_min <= qos[id_idx][`DCR_QOS_MIN];
         o_chip_hit <= cs_match(i_axi_addr_hi, chip_sel);
      end
   end

endmodule // dcr_regs

//--- dcr_defs.vh
/*
 Constants for the memory controller timing and configuration registers:
 byte offsets, field positions, reset values and state codes.
 Assumes inclusion by the register file, its checker and its bench.
*/
`ifndef DCR_DEFS_VH
`define DCR_DEFS_VH

// Register byte offsets
`define DCR_OFS_WR_RECOVERY 12'h038
`define DCR_OFS_WR_TO_RD 12'h03c
`define DCR_OFS_PD_EXIT 12'h040
`define DCR_OFS_SR_EXIT 12'h044
`define DCR_OFS_SR_ENTRY 12'h048
`define DCR_OFS_MEM_SETUP2 12'h04c
`define DCR_OFS_REFRESH 12'h050
`define DCR_OFS_QOS_BASE 12'h100
`define DCR_OFS_QOS_LAST 12'h13c
`define DCR_OFS_CHIP_SEL 12'h200
`define DCR_OFS_STATE 12'h300
`define DCR_OFS_CS_PROBE 12'h304
`define DCR_OFS_CS_RESULT 12'h308

// Reset values
`define DCR_RST_WR_RECOVERY 3'h3
`define DCR_RST_WR_TO_RD 3'h2
`define DCR_RST_PD_EXIT 8'h01
`define DCR_RST_SR_EXIT 8'h0a
`define DCR_RST_SR_ENTRY 8'h14
`define DCR_RST_MEM_SETUP2 11'h000
`define DCR_RST_REFRESH 12'h000
`define DCR_RST_QOS 10'h000
`define DCR_RST_CHIP_SEL 17'h0_ff00

// memory_setup_two fields
`define DCR_M2_READ_DELAY_HI 10
`define DCR_M2_READ_DELAY_LO 9
`define DCR_M2_TYPE_HI 8
`define DCR_M2_TYPE_LO 6
`define DCR_M2_WIDTH_HI 5
`define DCR_M2_WIDTH_LO 4
`define DCR_M2_CKE_INIT 3
`define DCR_M2_DQM_INIT 2
`define DCR_M2_BUS_FASTER 1
`define DCR_M2_SYNC 0

// refresh_setup fields
`define DCR_RF_PRESCALE_HI 11
`define DCR_RF_PRESCALE_LO 3
`define DCR_RF_MAX_OUTS_HI 2
`define DCR_RF_MAX_OUTS_LO 0

// master_qos_setup fields
`define DCR_QOS_MAX_HI 9
`define DCR_QOS_MAX_LO 2
`define DCR_QOS_MIN 1
`define DCR_QOS_EN 0

// chip_select_setup fields
`define DCR_CS_BRC 16
`define DCR_CS_MATCH_HI 15
`define DCR_CS_MATCH_LO 8
`define DCR_CS_MASK_HI 7
`define DCR_CS_MASK_LO 0

// Memory type and width encodings
`define DCR_TYPE_SDR 3'h0
`define DCR_TYPE_DDR 3'h1
`define DCR_TYPE_EDRAM 3'h2
`define DCR_TYPE_LPDDR 3'h3
`define DCR_WIDTH_16 2'h0
`define DCR_WIDTH_32 2'h1
`define DCR_WIDTH_64 2'h2

// Master identification step and count
`define DCR_ID_STEP 8'h20
`define DCR_NUM_MASTERS 8

// Controller state codes
`define DCR_ST_CONFIG 2'h0
`define DCR_ST_READY 2'h1
`define DCR_ST_LOWPWR 2'h2

`endif

//--- dcr_regs_monitor.sv
/*
 Checker for dcr_regs: APB answer timing, state gating, pin levels, decode flags.
 Assumes binding to dcr_regs and seeing its ports only.
*/
`timescale 1ns/1ps
`include "dcr_defs.vh"
module dcr_regs_monitor
(
   // Clock and reset
   input wire i_clk,
   input wire i_arst_n,
   // APB and engine state
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [1:0] i_ctrl_state,
   // Watched outputs
   input wire [31:0] o_prdata,
   input wire o_pready,
   input wire o_pslverr,
   input wire [2:0] o_wr_recovery,
   input wire o_is_ddr,
   input wire o_is_lpddr,
   input wire [1:0] o_bytes_log2,
   input wire o_width_bad,
   input wire o_mem_cke,
   input wire o_mem_dqm
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // Setup phase and a write access to the recovery word
   wire setup = i_psel && !i_penable;
   wire wr38 = i_psel && i_penable && i_pwrite && (i_paddr == `DCR_OFS_WR_RECOVERY);
   wire open_st = (i_ctrl_state == `DCR_ST_CONFIG) || (i_ctrl_state == `DCR_ST_LOWPWR);
   // Bus answer and gating
   a_pready_one_cycle: assert property (setup |=> o_pready ##1 !o_pready)
      else $error("pready is not a single cycle after setup");
   a_closed_read_zero: assert property (setup && !i_pwrite && (i_ctrl_state == `DCR_ST_READY) &&
      (i_paddr == `DCR_OFS_WR_RECOVERY) |=> o_pready && (o_prdata == 32'h0000_0000))
      else $error("closed state read returned data");
   a_closed_write_kept: assert property (wr38 && (i_ctrl_state == `DCR_ST_READY) |-> ##2 $stable(o_wr_recovery))
      else $error("closed state write changed recovery value");
   a_open_write_stored: assert property (wr38 && open_st |-> ##2 o_wr_recovery == $past(i_pwdata[2:0], 2))
      else $error("open state write not stored");
   a_idle_data_zero: assert property (!o_pready |-> (o_prdata == 32'h0000_0000) && !o_pslverr)
      else $error("read data or error outside access");
   // Memory pin levels outside config
   a_ready_pins: assert property (i_ctrl_state == `DCR_ST_READY |=> o_mem_cke && !o_mem_dqm)
      else $error("pins wrong in ready state");
   a_lowpwr_pins: assert property (i_ctrl_state == `DCR_ST_LOWPWR |=> !o_mem_cke && !o_mem_dqm)
      else $error("pins wrong in low-power state");
   // Decode flags
   a_lpddr_is_ddr: assert property (o_is_lpddr |-> o_is_ddr)
      else $error("low-power type without double rate");
   a_width_bad_flag: assert property (o_width_bad |-> o_bytes_log2 == 2'h1)
      else $error("reserved width not reported as 16 bits");
   // Main scenarios
   c_closed_write: cover property (wr38 && (i_ctrl_state == `DCR_ST_READY));
   c_open_write: cover property (wr38 && (i_ctrl_state == `DCR_ST_LOWPWR));
   c_slave_error: cover property (o_pslverr);
endmodule // dcr_regs_monitor

bind dcr_regs dcr_regs_monitor u_mon (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .i_ctrl_state(i_ctrl_state), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_wr_recovery(o_wr_recovery), .o_is_ddr(o_is_ddr), .o_is_lpddr(o_is_lpddr),
   .o_bytes_log2(o_bytes_log2), .o_width_bad(o_width_bad), .o_mem_cke(o_mem_cke), .o_mem_dqm(o_mem_dqm));

//--- dcr_engine_model.sv
/*
 Command engine stand-in: reports the controller state to the register block.
 Assumes the bench requests states on i_clk edges.
*/
`timescale 1ns/1ps
module dcr_engine_model
(
   // Clock and reset
   input wire i_clk,
   input wire i_arst_n,
   // State request from the bench
   input wire [1:0] i_req_state,
   // State seen by the register block
   output reg [1:0] o_ctrl_state
);
   // Registered state, config after reset
   always @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_ctrl_state <= 2'h0;
      else
         o_ctrl_state <= i_req_state;
   end
endmodule // dcr_engine_model

//--- dcr_regs_tb.sv
/*
 Self-checking bench for dcr_regs: APB accesses, state gating, decode outputs.
 Assumes the engine model supplies the controller state.
*/
`timescale 1ns/1ps
`include "dcr_defs.vh"
module dcr_regs_tb;
   // Offsets, reset values and writable bits, index 0 in the low slice
   localparam [107:0] OFS = {12'h200, 12'h100, 12'h050, 12'h04c, 12'h048, 12'h044, 12'h040, 12'h03c, 12'h038};
   localparam [287:0] RSTV = {32'h0000_ff00, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0014,
      32'h0000_000a, 32'h0000_0001, 32'h0000_0002, 32'h0000_0003};
   localparam [287:0] MSK = {32'h0001_ffff, 32'h0000_03ff, 32'h0000_0fff, 32'h0000_07ff, 32'h0000_00ff,
      32'h0000_00ff, 32'h0000_00ff, 32'h0000_0007, 32'h0000_0007};
   // Bench drive
   reg i_clk = 1'b0;
   reg i_arst_n = 1'b0;
   reg i_psel = 1'b0;
   reg i_penable = 1'b0;
   reg i_pwrite = 1'b0;
   reg [11:0] i_paddr = 12'h000;
   reg [31:0] i_pwdata = 32'h0000_0000;
   reg [1:0] req_state = 2'h0;
   reg [7:0] i_axi_id = 8'h00;
   reg [7:0] i_axi_addr_hi = 8'h00;
   // Design outputs
   wire [1:0] i_ctrl_state;
   wire [31:0] o_prdata;
   wire [2:0] o_wr_recovery, o_wr_to_rd, o_max_outs_refs;
   wire [7:0] o_pd_exit, o_sr_exit, o_sr_entry, o_qos_max;
   wire [1:0] o_read_delay, o_bytes_log2;
   wire [8:0] o_prescale;
   wire o_pready, o_pslverr, o_is_ddr, o_is_lpddr, o_width_bad, o_sync, o_bus_clock_faster_flag;
   wire o_bank_row_col, o_mem_cke, o_mem_dqm, o_qos_enable, o_qos_min, o_chip_hit;
   integer n_fail = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer i;
   reg [31:0] rd;
   reg err;

   // 200 MHz clock
   always #2.5 i_clk = ~i_clk;

   dcr_regs uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_ctrl_state(i_ctrl_state), .o_wr_recovery(o_wr_recovery), .o_wr_to_rd(o_wr_to_rd),
      .o_pd_exit(o_pd_exit), .o_sr_exit(o_sr_exit), .o_sr_entry(o_sr_entry), .o_read_delay(o_read_delay),
      .o_is_ddr(o_is_ddr), .o_is_lpddr(o_is_lpddr), .o_bytes_log2(o_bytes_log2), .o_width_bad(o_width_bad),
      .o_sync(o_sync), .o_bus_clock_faster_flag(o_bus_clock_faster_flag), .o_prescale(o_prescale),
      .o_max_outs_refs(o_max_outs_refs), .o_bank_row_col(o_bank_row_col), .o_mem_cke(o_mem_cke),
      .o_mem_dqm(o_mem_dqm), .i_axi_id(i_axi_id), .o_qos_enable(o_qos_enable), .o_qos_max(o_qos_max),
      .o_qos_min(o_qos_min), .i_axi_addr_hi(i_axi_addr_hi), .o_chip_hit(o_chip_hit));

   dcr_engine_model u_eng (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req_state(req_state), .o_ctrl_state(i_ctrl_state));

   // Verdict and end of run
   task end_sim;
   begin
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask

   // Compare and count
   task chk(input string name, input [31:0] seen, input [31:0] exp);
   begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         $display("unexpected %0s expected %h seen %h", name, exp, seen);
         n_fail = n_fail + 1;
      end
   end
   endtask

   // One APB transfer; data and error taken at the pready edge
   task apb(input wr, input [11:0] a, input [31:0] d);
   begin
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      @(posedge i_clk);
      while (o_pready !== 1'b1)
      begin
         @(posedge i_clk);
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   end
   endtask

   // Let registered outputs land
   task settle;
   begin
      @(posedge i_clk);
      @(negedge i_clk);
   end
   endtask

   // Present an ID and upper address to the lookups
   task look(input [7:0] id, input [7:0] ah);
   begin
      @(posedge i_clk);
      i_axi_id <= id;
      i_axi_addr_hi <= ah;
      settle;
   end
   endtask

   // Move the engine to a state
   task go_state(input [1:0] s);
   begin
      @(posedge i_clk);
      req_state <= s;
      settle;
      settle;
   end
   endtask

   // Hang guard
   always @(posedge i_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_fail = n_fail + 1;
         end_sim;
      end
   end

   // Main sequence
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_arst_n <= 1'b1;
      // Reset values and writable bits of the timing, setup, refresh and chip registers and QoS slot 0
      for (i = 0; i < 9; i = i + 1)
      begin
         apb(1'b0, OFS[12*i +: 12], 32'h0000_0000);
         chk("reset value", rd, RSTV[32*i +: 32]);
         apb(1'b1, OFS[12*i +: 12], 32'hffff_ffff);
         apb(1'b0, OFS[12*i +: 12], 32'h0000_0000);
         chk("writable bits", rd, MSK[32*i +: 32]);
         apb(1'b1, OFS[12*i +: 12], 32'h0000_0000);
      end
      // Engine copies of the timing values
      apb(1'b1, 12'h038, 32'h0000_0005);
      apb(1'b1, 12'h03c, 32'h0000_0006);
      apb(1'b1, 12'h040, 32'h0000_0081);
      apb(1'b1, 12'h044, 32'h0000_005a);
      apb(1'b1, 12'h048, 32'h0000_00c3);
      apb(1'b1, 12'h050, 32'h0000_0d2e);
      settle;
      chk("wr_recovery", 32'(o_wr_recovery), 32'h0000_0005);
      chk("wr_to_rd", 32'(o_wr_to_rd), 32'h0000_0006);
      chk("pd_exit", 32'(o_pd_exit), 32'h0000_0081);
      chk("sr_exit", 32'(o_sr_exit), 32'h0000_005a);
      chk("sr_entry", 32'(o_sr_entry), 32'h0000_00c3);
      chk("refresh", {20'h0_0000, o_prescale, o_max_outs_refs}, 32'h0000_0d2e);
      // Every type, width, latency and clock flag code
      for (i = 0; i < 4; i = i + 1)
      begin
         apb(1'b1, 12'h04c, i * 593);
         settle;
         chk("is_ddr", 32'(o_is_ddr), 32'(i == 1 || i == 3));
         chk("is_lpddr", 32'(o_is_lpddr), 32'(i == 3));
         chk("bytes_log2", 32'(o_bytes_log2), (i == 3) ? 1 : i + 1);
         chk("width_bad", 32'(o_width_bad), 32'(i == 3));
         chk("read_delay", 32'(o_read_delay), i);
         chk("clock flags", {30'h0, o_bus_clock_faster_flag, o_sync}, i);
      end
      // Pin init levels in config, then running states
      apb(1'b1, 12'h04c, 32'h0000_0008);
      settle;
      chk("cke dqm", {30'h0, o_mem_cke, o_mem_dqm}, 32'h0000_0002);
      apb(1'b1, 12'h04c, 32'h0000_0004);
      settle;
      chk("cke dqm", {30'h0, o_mem_cke, o_mem_dqm}, 32'h0000_0001);
      go_state(`DCR_ST_READY);
      chk("cke dqm", {30'h0, o_mem_cke, o_mem_dqm}, 32'h0000_0002);
      // Closed state reads zero and ignores writes; low-power is open
      apb(1'b0, 12'h038, 32'h0000_0000);
      chk("closed read", rd, 32'h0000_0000);
      apb(1'b0, 12'h300, 32'h0000_0000);
      chk("state ready", rd, 32'h0000_0001);
      apb(1'b1, 12'h038, 32'h0000_0002);
      go_state(`DCR_ST_LOWPWR);
      chk("cke dqm", {30'h0, o_mem_cke, o_mem_dqm}, 32'h0000_0000);
      apb(1'b0, 12'h038, 32'h0000_0000);
      chk("kept value", rd, 32'h0000_0005);
      apb(1'b1, 12'h038, 32'h0000_0001);
      apb(1'b0, 12'h038, 32'h0000_0000);
      chk("low-power write", rd, 32'h0000_0001);
      apb(1'b0, 12'h300, 32'h0000_0000);
      chk("state low-power", rd, 32'h0000_0002);
      go_state(`DCR_ST_CONFIG);
      // Unmapped address and the unused QoS words
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("slave error", 32'(err), 32'h0000_0001);
      apb(1'b1, 12'h120, 32'hffff_ffff);
      apb(1'b0, 12'h120, 32'h0000_0000);
      chk("unused qos", {rd[30:0], err}, 32'h0000_0000);
      // Per-master QoS selected by ID in steps of 0x20
      for (i = 0; i < 8; i = i + 1)
         apb(1'b1, 12'h100 + 4 * i, {22'h0, 8'(8'h11 * i), i[0], ~i[0]});
      for (i = 0; i < 8; i = i + 1)
      begin
         look(8'(32 * i + i), 8'h00);
         chk("qos", {22'h0, o_qos_max, o_qos_min, o_qos_enable}, {22'h0, 8'(8'h11 * i), i[0], ~i[0]});
      end
      // Chip select match and mask
      look(8'h00, 8'h37);
      chk("hit zero mask", 32'(o_chip_hit), 32'h0000_0001);
      apb(1'b1, 12'h200, 32'h0001_a5f0);
      look(8'h00, 8'ha3);
      chk("bank row col", 32'(o_bank_row_col), 32'h0000_0001);
      chk("hit masked", 32'(o_chip_hit), 32'h0000_0001);
      look(8'h00, 8'h25);
      chk("miss masked", 32'(o_chip_hit), 32'h0000_0000);
      // Probe register and its match result
      apb(1'b1, 12'h304, 32'h0000_00a3);
      apb(1'b0, 12'h304, 32'h0000_0000);
      chk("probe value", rd, 32'h0000_00a3);
      apb(1'b0, 12'h308, 32'h0000_0000);
      chk("probe hit", rd, 32'h0000_0001);
      apb(1'b1, 12'h304, 32'h0000_0025);
      apb(1'b0, 12'h308, 32'h0000_0000);
      chk("probe miss", rd, 32'h0000_0000);
      apb(1'b1, 12'h200, 32'h0000_a5ff);
      look(8'h00, 8'ha4);
      chk("miss full mask", {31'h0, o_chip_hit} | {30'h0, o_bank_row_col, 1'b0}, 32'h0000_0000);
      look(8'h00, 8'ha5);
      chk("hit full mask", 32'(o_chip_hit), 32'h0000_0001);
      end_sim;
   end
endmodule // dcr_regs_tb
